// File: core/rtcac_params.svh
// Constants of the real-time counter control block: offsets, fields, reset values.
// Assumes inclusion by bare name from the package and design modules.
`ifndef RTCAC_PARAMS_SVH
`define RTCAC_PARAMS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define RTCAC_OFF_COUNT_HIGH   16'hF900
`define RTCAC_OFF_COUNT_LOW    16'hF904
`define RTCAC_OFF_ALARM_HIGH   16'hF908
`define RTCAC_OFF_ALARM_LOW    16'hF90C
`define RTCAC_OFF_CONTROL      16'hF910
`define RTCAC_OFF_STATUS       16'hF914
`define RTCAC_OFF_IRQ_ENABLE   16'hF918

// ****************************************
// Control field positions
// ****************************************
`define RTCAC_BIT_ROLL_DIS     7
`define RTCAC_BIT_ALARM_DIS    6
`define RTCAC_BIT_PRE_FRZ      5
`define RTCAC_BIT_UPPER_FRZ    4
`define RTCAC_BIT_CLEAR        3
`define RTCAC_BIT_TEST_CLK     1
`define RTCAC_BIT_PAR_TEST     0

// ****************************************
// Status field positions
// ****************************************
`define RTCAC_BIT_ROLL_EVT     1
`define RTCAC_BIT_ALARM_EVT    0

// ****************************************
// Reset values and widths
// ****************************************
`define RTCAC_RST_ALARM_LOW    32'h0000_0000
`define RTCAC_RST_ALARM_HIGH   12'h000
`define RTCAC_RST_CONTROL      8'hC0
`define RTCAC_RST_STATUS       2'h0
`define RTCAC_RST_IRQ_ENABLE   2'h3
`define RTCAC_COUNT_W          44
`define RTCAC_STAGES           6
`define RTCAC_ADDR_W           16

`endif

// File: core/rtcac_pkg.sv
// Types shared by the real-time counter control block.
// Assumes rtcac_params.svh is on the include path.
`include "rtcac_params.svh"

package rtcac_pkg;

  typedef logic [`RTCAC_COUNT_W-1:0] rtcac_count_t;

  // Control register image, bit 7 down to bit 0
  typedef struct packed {
    logic roll_irq_disable;
    logic alarm_irq_disable;
    logic prescaler_freeze;
    logic upper_counter_freeze;
    logic counter_clear;
    logic reserved2;
    logic test_clock_select;
    logic parallel_count_test;
  } rtcac_ctrl_s;

  // Event flags, bit 1 down to bit 0
  typedef struct packed {
    logic rollover_event;
    logic alarm_event;
  } rtcac_evt_s;

endpackage : rtcac_pkg

// File: core/rtcac_sync.sv
// Two-stage reset release for the block.
// Assumes an asynchronous active-low reset and one clock.
module rtcac_sync (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  // Released reset
  output logic      rst_b_out
);

  logic stage1;
  logic next_stage1;
  logic next_rst_b;

  always_comb begin
    next_stage1 = 1'b1;
    next_rst_b  = stage1;
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      stage1    <= 1'b0;
      rst_b_out <= 1'b0;
    end else begin
      stage1    <= next_stage1;
      rst_b_out <= next_rst_b;
    end
  end

endmodule // rtcac_sync

// File: core/rtcac_counter.sv
// 44-bit time counter built of five 8-bit stages and one 4-bit stage.
// Assumes the slow clock input is synchronous to clk_in and slower than half its rate.
`include "rtcac_params.svh"
module rtcac_counter (
  // Clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  rst_b_in,
  // Control and time base
  input  wire rtcac_pkg::rtcac_ctrl_s ctrl_in,
  input  wire logic                  slow_clock_in,
  // Count value
  output rtcac_pkg::rtcac_count_t    count_out
);

  rtcac_pkg::rtcac_ctrl_s  ctrl_q;
  logic                    slow_q;
  rtcac_pkg::rtcac_count_t next_count;
  logic                    tick;

  // ****************************************
  // Control staging and tick
  // ****************************************
  // Control passes a register before use so a bus write never meets a count mid-update
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl_q <= rtcac_pkg::rtcac_ctrl_s'(`RTCAC_RST_CONTROL);
      slow_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_in; // RL18
      slow_q <= slow_clock_in;
    end
  end

  // ****************************************
  // Stage chain
  // ****************************************
  always_comb begin
    logic [`RTCAC_STAGES-1:0] adv;
    logic                     lower_ones;
    adv        = '0;
    lower_ones = 1'b1;
    next_count = count_out;
    tick       = ctrl_q.test_clock_select | (slow_clock_in & ~slow_q); // RL8
    for (int k = 0; k < `RTCAC_STAGES; k++) begin
      if (k == 0) begin
        adv[k] = tick & ~ctrl_q.prescaler_freeze; // RL5
      end else begin
        adv[k] = tick & ~ctrl_q.upper_counter_freeze // RL6
                 & (ctrl_q.parallel_count_test | lower_ones); // RL9 RL13
      end
      if (k < `RTCAC_STAGES - 1) begin
        lower_ones = lower_ones & (&count_out[k*8 +: 8]);
        if (adv[k]) begin
          next_count[k*8 +: 8] = count_out[k*8 +: 8] + 8'h01;
        end
      end else if (adv[k]) begin
        next_count[43:40] = count_out[43:40] + 4'h1;
      end
    end
    if (ctrl_q.counter_clear) begin
      next_count = '0; // RL7
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      count_out <= '0;
    end else begin
      count_out <= next_count;
    end
  end

endmodule // rtcac_counter

// File: core/rtcac_top.sv
// Real-time counter with alarm compare, control and event status, AXI4-Lite slave.
// Assumes one clock CLK_IN at 10 MHz; slow clock input synchronous to it.
//
// Contract
// RL1: Low alarm word is read/write, resets to zero, gives compare bits 31:0.
// RL2: Alarm flag sets when the 44-bit count equals the joined alarm value.
// RL3: Rollover disable bit 7 resets to 1; when 0, all-ones count interrupts.
// RL4: Alarm disable bit 6 resets to 1; when 0, alarm match interrupts.
// RL5: Prescaler freeze bit 5 holds the lowest eight count bits.
// RL6: Upper freeze bit 4 holds the upper thirty-six count bits.
// RL7: Clear bit 3 forces the count to zero until written back to 0.
// RL8: Test clock bit 1 counts on the bus clock instead of slow input.
// RL9: Parallel test bit 0 advances all six stages together.
// RL10: Software keeps freeze and test bits at zero.
// RL11: Rollover flag, status bit 1, resets 0, sets on rollover, write 0 clears.
// RL12: Alarm flag, status bit 0, resets 0, sets on match, write 0 clears.
// RL13: Stages in series; later stage advances when lower stages are all ones.
// RL14: One interrupt output, OR of rollover and alarm sources.
// RL15: High alarm field of 12 bits gives compare bits 43:32.
// RL16: Software reads the counter twice until two reads agree.
// RL17: Interrupt only while a flag is 1 and its disable is 0; writing 1 ignored.
// RL18: Control bits pass a register stage before steering the counter.
`include "rtcac_params.svh"
module rtcac_top (
  // Clock and reset
  input  wire logic                     CLK_IN,
  input  wire logic                     RST_B_IN,
  // Time base
  input  wire logic                     SLOW_CLOCK_IN,
  // AXI4-Lite write address
  input  wire logic [`RTCAC_ADDR_W-1:0] AXI_AWADDR_IN,
  input  wire logic [2:0]               AXI_AWPROT_IN,
  input  wire logic                     AXI_AWVALID_IN,
  output logic                          AXI_AWREADY_OUT,
  // AXI4-Lite write data
  input  wire logic [31:0]              AXI_WDATA_IN,
  input  wire logic [3:0]               AXI_WSTRB_IN,
  input  wire logic                     AXI_WVALID_IN,
  output logic                          AXI_WREADY_OUT,
  // AXI4-Lite write response
  output logic [1:0]                    AXI_BRESP_OUT,
  output logic                          AXI_BVALID_OUT,
  input  wire logic                     AXI_BREADY_IN,
  // AXI4-Lite read address
  input  wire logic [`RTCAC_ADDR_W-1:0] AXI_ARADDR_IN,
  input  wire logic [2:0]               AXI_ARPROT_IN,
  input  wire logic                     AXI_ARVALID_IN,
  output logic                          AXI_ARREADY_OUT,
  // AXI4-Lite read data
  output logic [31:0]                   AXI_RDATA_OUT,
  output logic [1:0]                    AXI_RRESP_OUT,
  output logic                          AXI_RVALID_OUT,
  input  wire logic                     AXI_RREADY_IN,
  // Interrupt to the system interrupt controller
  output logic                          IRQ_OUT
);

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  logic                    rst_b;
  rtcac_pkg::rtcac_count_t count;

  // ****************************************
  // Register decode helpers
  // ****************************************
  function automatic logic is_mapped(input logic [`RTCAC_ADDR_W-1:0] addr);
    case (addr)
      `RTCAC_OFF_COUNT_HIGH, `RTCAC_OFF_COUNT_LOW, `RTCAC_OFF_ALARM_HIGH,
      `RTCAC_OFF_ALARM_LOW, `RTCAC_OFF_CONTROL, `RTCAC_OFF_STATUS,
      `RTCAC_OFF_IRQ_ENABLE: is_mapped = 1'b1;
      default:               is_mapped = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old_val,
                                        input logic [31:0] wdata,
                                        input logic [3:0]  wstrb);
    merge = old_val;
    for (int b = 0; b < 4; b++) begin
      if (wstrb[b]) begin
        merge[b*8 +: 8] = wdata[b*8 +: 8];
      end
    end
  endfunction

  // ****************************************
  // Reset release
  // ****************************************
  rtcac_sync u_sync (
    .clk_in    (CLK_IN),
    .rst_b_in  (RST_B_IN),
    .rst_b_out (rst_b)
  );

  // ****************************************
  // Register state and bus slave
  // ****************************************
  logic [31:0]                  alarm_low;
  logic [11:0]                  alarm_high;
  rtcac_pkg::rtcac_ctrl_s       ctrl;
  rtcac_pkg::rtcac_evt_s        status;
  logic [1:0]                   irq_enable;
  logic                         aw_held;
  logic [`RTCAC_ADDR_W-1:0]     aw_addr;
  logic                         w_held;
  logic [31:0]                  w_data;
  logic [3:0]                   w_strb;
  logic                         at_max_q;
  logic                         match_q;

  logic [31:0]                  next_alarm_low;
  logic [11:0]                  next_alarm_high;
  rtcac_pkg::rtcac_ctrl_s       next_ctrl;
  rtcac_pkg::rtcac_evt_s        next_status;
  logic [1:0]                   next_irq_enable;
  logic                         next_aw_held;
  logic [`RTCAC_ADDR_W-1:0]     next_aw_addr;
  logic                         next_w_held;
  logic [31:0]                  next_w_data;
  logic [3:0]                   next_w_strb;
  logic                         next_bvalid;
  logic [1:0]                   next_bresp;
  logic                         next_rvalid;
  logic [31:0]                  next_rdata;
  logic [1:0]                   next_rresp;
  logic                         next_at_max;
  logic                         next_match;

  logic                         do_write;
  logic                         do_read;
  logic                         roll_hit;
  logic                         alarm_hit;

  // Events are edges of the compare so a frozen or stopped count sets a flag once
  assign next_at_max = &count;
  assign next_match  = (count == {alarm_high, alarm_low}); // RL2 RL15
  assign roll_hit    = next_at_max & ~at_max_q; // RL3
  assign alarm_hit   = next_match & ~match_q;

  assign AXI_AWREADY_OUT = ~aw_held & ~AXI_BVALID_OUT;
  assign AXI_WREADY_OUT  = ~w_held & ~AXI_BVALID_OUT;
  assign AXI_ARREADY_OUT = ~AXI_RVALID_OUT;

  always_comb begin
    logic                     aw_now;
    logic                     w_now;
    logic [`RTCAC_ADDR_W-1:0] wa;
    logic [31:0]              wd;
    logic [3:0]               ws;
    logic [31:0]              wr_val;
    aw_now          = AXI_AWVALID_IN & AXI_AWREADY_OUT;
    w_now           = AXI_WVALID_IN & AXI_WREADY_OUT;
    wa              = aw_held ? aw_addr : AXI_AWADDR_IN;
    wd              = w_held ? w_data : AXI_WDATA_IN;
    ws              = w_held ? w_strb : AXI_WSTRB_IN;
    do_write        = (aw_held | aw_now) & (w_held | w_now);
    do_read         = AXI_ARVALID_IN & AXI_ARREADY_OUT;
    next_aw_held    = (aw_held | aw_now) & ~do_write;
    next_aw_addr    = aw_now ? AXI_AWADDR_IN : aw_addr;
    next_w_held     = (w_held | w_now) & ~do_write;
    next_w_data     = w_now ? AXI_WDATA_IN : w_data;
    next_w_strb     = w_now ? AXI_WSTRB_IN : w_strb;
    next_bvalid     = AXI_BVALID_OUT & ~AXI_BREADY_IN;
    next_bresp      = AXI_BRESP_OUT;
    next_rvalid     = AXI_RVALID_OUT & ~AXI_RREADY_IN;
    next_rdata      = AXI_RDATA_OUT;
    next_rresp      = AXI_RRESP_OUT;
    next_alarm_low  = alarm_low;
    next_alarm_high = alarm_high;
    next_ctrl       = ctrl;
    next_irq_enable = irq_enable;
    next_status     = status;
    wr_val          = '0;

    // Write side: clears first, so an event in the same cycle still lands below
    if (do_write) begin
      next_bvalid = 1'b1;
      next_bresp  = is_mapped(wa) ? RESP_OKAY : RESP_SLVERR;
      case (wa)
        `RTCAC_OFF_ALARM_LOW: begin
          next_alarm_low = merge(alarm_low, wd, ws); // RL1
        end
        `RTCAC_OFF_ALARM_HIGH: begin
          wr_val          = merge({20'h00000, alarm_high}, wd, ws);
          next_alarm_high = wr_val[11:0]; // RL15
        end
        `RTCAC_OFF_CONTROL: begin
          wr_val    = merge({24'h000000, ctrl}, wd, ws);
          next_ctrl = rtcac_pkg::rtcac_ctrl_s'(wr_val[7:0]);
          next_ctrl.reserved2 = 1'b0;
        end
        `RTCAC_OFF_STATUS: begin
          if (ws[0]) begin
            // A written 0 clears, as a status read does; a written 1 leaves the flag alone
            next_status.rollover_event = status.rollover_event
                                         & wd[`RTCAC_BIT_ROLL_EVT]; // RL11 RL17
            next_status.alarm_event    = status.alarm_event
                                         & wd[`RTCAC_BIT_ALARM_EVT]; // RL12 RL17
          end
        end
        `RTCAC_OFF_IRQ_ENABLE: begin
          wr_val          = merge({30'h00000000, irq_enable}, wd, ws);
          next_irq_enable = wr_val[1:0];
        end
        default: begin
          wr_val = '0;
        end
      endcase
    end

    // Read side; counter words are a live snapshot, software double-reads them
    if (do_read) begin
      next_rvalid = 1'b1;
      next_rresp  = is_mapped(AXI_ARADDR_IN) ? RESP_OKAY : RESP_SLVERR;
      case (AXI_ARADDR_IN)
        `RTCAC_OFF_COUNT_HIGH:  next_rdata = {20'h00000, count[43:32]}; // RL16
        `RTCAC_OFF_COUNT_LOW:   next_rdata = count[31:0]; // RL16
        `RTCAC_OFF_ALARM_HIGH:  next_rdata = {20'h00000, alarm_high};
        `RTCAC_OFF_ALARM_LOW:   next_rdata = alarm_low;
        `RTCAC_OFF_CONTROL:     next_rdata = {24'h000000, ctrl};
        `RTCAC_OFF_STATUS: begin
          next_rdata  = {30'h00000000, status};
          next_status = '0;
        end
        `RTCAC_OFF_IRQ_ENABLE:  next_rdata = {30'h00000000, irq_enable};
        default:                next_rdata = 32'h0000_0000;
      endcase
    end

    // Hardware set wins over any clear in the same cycle
    if (roll_hit) begin
      next_status.rollover_event = 1'b1; // RL11
    end
    if (alarm_hit) begin
      next_status.alarm_event = 1'b1; // RL2 RL12
    end
  end

  always_ff @(posedge CLK_IN or negedge rst_b) begin
    if (!rst_b) begin
      alarm_low      <= `RTCAC_RST_ALARM_LOW; // RL1
      alarm_high     <= `RTCAC_RST_ALARM_HIGH;
      ctrl           <= rtcac_pkg::rtcac_ctrl_s'(`RTCAC_RST_CONTROL); // RL3 RL4
      status         <= rtcac_pkg::rtcac_evt_s'(`RTCAC_RST_STATUS); // RL11 RL12
      irq_enable     <= `RTCAC_RST_IRQ_ENABLE;
      aw_held        <= 1'b0;
      aw_addr        <= '0;
      w_held         <= 1'b0;
      w_data         <= 32'h0000_0000;
      w_strb         <= 4'h0;
      AXI_BVALID_OUT <= 1'b0;
      AXI_BRESP_OUT  <= 2'h0;
      AXI_RVALID_OUT <= 1'b0;
      AXI_RDATA_OUT  <= 32'h0000_0000;
      AXI_RRESP_OUT  <= 2'h0;
      at_max_q       <= 1'b0;
      // Count and alarm both start at zero; no spurious match after reset
      match_q        <= 1'b1;
    end else begin
      alarm_low      <= next_alarm_low;
      alarm_high     <= next_alarm_high;
      ctrl           <= next_ctrl;
      status         <= next_status;
      irq_enable     <= next_irq_enable;
      aw_held        <= next_aw_held;
      aw_addr        <= next_aw_addr;
      w_held         <= next_w_held;
      w_data         <= next_w_data;
      w_strb         <= next_w_strb;
      AXI_BVALID_OUT <= next_bvalid;
      AXI_BRESP_OUT  <= next_bresp;
      AXI_RVALID_OUT <= next_rvalid;
      AXI_RDATA_OUT  <= next_rdata;
      AXI_RRESP_OUT  <= next_rresp;
      at_max_q       <= next_at_max;
      match_q        <= next_match;
    end
  end

  // ****************************************
  // Interrupt output
  // ****************************************
  logic irq;
  logic next_irq;

  always_comb begin
    next_irq = (status.rollover_event & ~ctrl.roll_irq_disable & irq_enable[1]) // RL3 RL17
             | (status.alarm_event & ~ctrl.alarm_irq_disable & irq_enable[0]); // RL4 RL14
  end

  always_ff @(posedge CLK_IN or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

  assign IRQ_OUT = irq;

  // ****************************************
  // Counter
  // ****************************************
  // Freeze and test bits are honoured even though software should leave them at 0
  rtcac_counter u_counter (
    .clk_in        (CLK_IN),
    .rst_b_in      (rst_b),
    .ctrl_in       (ctrl), // RL10
    .slow_clock_in (SLOW_CLOCK_IN),
    .count_out     (count)
  );

endmodule // rtcac_top

// File: tb/rtcac_top_props.sv
// Checker of the bus handshake, register reads and interrupt line.
// Assumes binding to rtcac_top; address and data are offered together.
`include "rtcac_params.svh"
module rtcac_top_props (
  // Clock and reset
  input wire logic        CLK_IN,
  input wire logic        RST_B_IN,
  // Register bus
  input wire logic [15:0] AXI_AWADDR_IN,
  input wire logic        AXI_AWVALID_IN,
  input wire logic        AXI_AWREADY_OUT,
  input wire logic [31:0] AXI_WDATA_IN,
  input wire logic        AXI_WVALID_IN,
  input wire logic        AXI_WREADY_OUT,
  input wire logic [1:0]  AXI_BRESP_OUT,
  input wire logic        AXI_BVALID_OUT,
  input wire logic        AXI_BREADY_IN,
  input wire logic [15:0] AXI_ARADDR_IN,
  input wire logic        AXI_ARVALID_IN,
  input wire logic        AXI_ARREADY_OUT,
  input wire logic [31:0] AXI_RDATA_OUT,
  input wire logic        AXI_RVALID_OUT,
  input wire logic        AXI_RREADY_IN,
  // Interrupt
  input wire logic        IRQ_OUT
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RST_B_IN);
  logic        wtake;
  logic        rtake;
  logic [31:0] alarm_low;
  logic [31:0] next_alarm_low;
  assign wtake = AXI_AWVALID_IN && AXI_AWREADY_OUT && AXI_WVALID_IN && AXI_WREADY_OUT;
  assign rtake = AXI_ARVALID_IN && AXI_ARREADY_OUT;
  // Shadow only valid for full-word writes
  assign next_alarm_low = (wtake && AXI_AWADDR_IN == 16'hF90C) ? AXI_WDATA_IN : alarm_low;
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) alarm_low <= 32'h0;
    else alarm_low <= next_alarm_low;
  end
  AST_WR_ANSWER: assert property (wtake |=> AXI_BVALID_OUT)
    else $error("write not answered");
  AST_WR_UNMAPPED: assert property (wtake && AXI_AWADDR_IN == 16'hF920 |=> AXI_BRESP_OUT == 2'h2)
    else $error("unmapped write not refused");
  AST_RD_ANSWER: assert property (rtake |=> AXI_RVALID_OUT)
    else $error("read not answered");
  AST_B_ONCE: assert property (AXI_BVALID_OUT && AXI_BREADY_IN |=> !AXI_BVALID_OUT)
    else $error("write response repeated");
  AST_WR_REFUSE: assert property (AXI_BVALID_OUT |-> !AXI_AWREADY_OUT && !AXI_WREADY_OUT)
    else $error("write taken while response pending");
  AST_RD_REFUSE: assert property (AXI_RVALID_OUT |-> !AXI_ARREADY_OUT)
    else $error("read taken while data pending");
  AST_ALARM_LOW_READ: assert property (
    rtake && AXI_ARADDR_IN == 16'hF90C |=> AXI_RDATA_OUT == alarm_low)
    else $error("low alarm word read back wrong");
  AST_STATUS_RESERVED: assert property (
    rtake && AXI_ARADDR_IN == 16'hF914 |=> AXI_RDATA_OUT[31:2] == 30'h0)
    else $error("status upper bits not zero");
  AST_IRQ_DISABLED: assert property (
    wtake && AXI_AWADDR_IN == 16'hF910 && AXI_WDATA_IN[7:6] == 2'h3
    |-> ##2 (!IRQ_OUT) [*2])
    else $error("interrupt while both sources disabled");
  AST_IRQ_RESET: assert property ($rose(RST_B_IN) |-> (!IRQ_OUT) [*3])
    else $error("interrupt high after reset");
endmodule // rtcac_top_props

bind rtcac_top rtcac_top_props u_rtcac_top_props (
  .CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN), .AXI_AWADDR_IN(AXI_AWADDR_IN),
  .AXI_AWVALID_IN(AXI_AWVALID_IN), .AXI_AWREADY_OUT(AXI_AWREADY_OUT),
  .AXI_WDATA_IN(AXI_WDATA_IN), .AXI_WVALID_IN(AXI_WVALID_IN),
  .AXI_WREADY_OUT(AXI_WREADY_OUT), .AXI_BRESP_OUT(AXI_BRESP_OUT),
  .AXI_BVALID_OUT(AXI_BVALID_OUT), .AXI_BREADY_IN(AXI_BREADY_IN),
  .AXI_ARADDR_IN(AXI_ARADDR_IN), .AXI_ARVALID_IN(AXI_ARVALID_IN),
  .AXI_ARREADY_OUT(AXI_ARREADY_OUT), .AXI_RDATA_OUT(AXI_RDATA_OUT),
  .AXI_RVALID_OUT(AXI_RVALID_OUT), .AXI_RREADY_IN(AXI_RREADY_IN), .IRQ_OUT(IRQ_OUT)
);

// File: tb/rtcac_timebase.sv
// Slow time base standing in for the external oscillator.
// Assumes clk_in is the bus clock; each tick spans five bus cycles.
module rtcac_timebase (
  // Bus clock
  input  wire logic clk_in,
  // Slow clock to the counter
  output logic      slow_clock_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial slow_clock_out = 1'b0;
  // Stands low between bursts so no stray tick is counted
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk_in);
      slow_clock_out <= 1'b1;
      repeat (2) @(posedge clk_in);
      slow_clock_out <= 1'b0;
      repeat (2) @(posedge clk_in);
    end
  endtask
endmodule // rtcac_timebase

// File: tb/testbench.sv
// Self-checking bench of the real-time counter control block.
// Assumes rtcac_top, its bound checker and the slow time base source.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst_b, slow, awvalid, awready, wvalid, wready;
  logic        bvalid, bready, arvalid, arready, rvalid, rready, irq;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_val;
  logic [3:0]  wstrb;
  logic [2:0]  prot;
  logic [1:0]  bresp, rresp, wr_resp, rd_resp;
  int          fails = 0;
  int          checks_done = 0;
  int          n;
  longint      cnt;
  int unsigned alo, ahi, ctrl, stat, ien;
  rtcac_top u_rtcac_top (
    .CLK_IN(clk), .RST_B_IN(rst_b), .SLOW_CLOCK_IN(slow),
    .AXI_AWADDR_IN(awaddr), .AXI_AWPROT_IN(prot), .AXI_AWVALID_IN(awvalid),
    .AXI_AWREADY_OUT(awready), .AXI_WDATA_IN(wdata), .AXI_WSTRB_IN(wstrb),
    .AXI_WVALID_IN(wvalid), .AXI_WREADY_OUT(wready), .AXI_BRESP_OUT(bresp),
    .AXI_BVALID_OUT(bvalid), .AXI_BREADY_IN(bready), .AXI_ARADDR_IN(araddr),
    .AXI_ARPROT_IN(prot), .AXI_ARVALID_IN(arvalid), .AXI_ARREADY_OUT(arready),
    .AXI_RDATA_OUT(rdata), .AXI_RRESP_OUT(rresp), .AXI_RVALID_OUT(rvalid),
    .AXI_RREADY_IN(rready), .IRQ_OUT(irq)
  );
  rtcac_timebase u_rtcac_timebase (.clk_in(clk), .slow_clock_out(slow));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ****
  // Bus tasks and model
  // ****
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  function automatic int unsigned mdl(input logic [15:0] a);
    case (a)
      16'hF900: return 32'(cnt >> 32) & 32'hFFF;
      16'hF904: return 32'(cnt);
      16'hF908: return ahi;
      16'hF90C: return alo;
      16'hF910: return ctrl;
      16'hF914: return stat;
      16'hF918: return ien;
      default: return 0;
    endcase
  endfunction
  // Ready is sampled at the falling edge, equal to its value at the next rise
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
    logic aw_ok, w_ok, b_ok;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    prot    <= 3'($urandom());
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(negedge clk);
      aw_ok = awvalid && awready;
      w_ok = wvalid && wready;
      b_ok = bvalid;
      wr_resp = bresp;
      @(posedge clk);
      awvalid <= awvalid && !aw_ok;
      wvalid <= wvalid && !w_ok;
    end while (!b_ok);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    logic ar_ok, r_ok;
    @(posedge clk);
    araddr  <= a;
    prot    <= 3'($urandom());
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(negedge clk);
      ar_ok = arvalid && arready;
      r_ok = rvalid;
      rd_val = rdata;
      rd_resp = rresp;
      @(posedge clk);
      if (ar_ok) arvalid <= 1'b0;
    end while (!r_ok);
    rready <= 1'b0;
  endtask
  task automatic wrm(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    wr(a, d, s);
    check({30'h0, wr_resp}, (a > 16'hF918) ? 32'h2 : 32'h0);
    case (a)
      16'hF908: ahi = d & 32'hFFF;
      16'hF90C: alo = d;
      16'hF910: ctrl = d & 32'hFB;
      16'hF914: if (s[0]) stat = stat & d;
      16'hF918: ien = d & 32'h3;
      default: ;
    endcase
    if (ctrl[3]) cnt = 0;
  endtask
  task automatic rdchk(input logic [15:0] a);
    rd(a);
    check(rd_val, mdl(a));
    check({30'h0, rd_resp}, (a > 16'hF918) ? 32'h2 : 32'h0);
    if (a == 16'hF914) stat = 0;
  endtask
  task automatic rdcnt;
    logic [31:0] h, l;
    do begin
      rd(16'hF900);
      h = rd_val;
      rd(16'hF904);
      l = rd_val;
      rd(16'hF900);
    end while (rd_val !== h);
    check(h, mdl(16'hF900));
    check(l, mdl(16'hF904));
  endtask
  task automatic irqchk;
    repeat (2) @(posedge clk);
    @(negedge clk);
    check({31'h0, irq}, (stat[1] & ~ctrl[7] & ien[1]) | (stat[0] & ~ctrl[6] & ien[0]));
  endtask
  // ****
  // Tests
  // ****
  initial begin
    rst_b = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb, prot} = '0;
    {alo, ahi, stat, cnt} = '0;
    ctrl = 32'hC0;
    ien = 32'h3;
    void'($urandom(32'h48FADDBB));
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    for (int a = 'hF900; a <= 'hF920; a += 4) rdchk(16'(a));
    $display("test reset values done");
    wrm(16'hF90C, $urandom());
    wrm(16'hF908, $urandom());
    wrm(16'hF918, 32'h1);
    wrm(16'hF920, $urandom());
    for (int a = 'hF900; a <= 'hF920; a += 4) rdchk(16'(a));
    wrm(16'hF908, 32'hFFF);
    wrm(16'hF918, 32'h3);
    $display("test register access done");
    n = 20 + $urandom_range(19);
    u_rtcac_timebase.tick(n);
    cnt += n;
    rdcnt();
    wrm(16'hF910, 32'hE0);
    u_rtcac_timebase.tick(5);
    rdcnt();
    wrm(16'hF910, 32'hD0);
    u_rtcac_timebase.tick(300);
    cnt = (cnt & ~64'hFF) | ((cnt + 300) & 64'hFF);
    rdcnt();
    wrm(16'hF910, 32'hC8);
    u_rtcac_timebase.tick(3);
    rdcnt();
    wrm(16'hF910, 32'hC0);
    u_rtcac_timebase.tick(7);
    cnt = 7;
    rdcnt();
    $display("test counting done");
    wrm(16'hF90C, 32'hB);
    wrm(16'hF908, 32'h0);
    wrm(16'hF910, 32'h80);
    u_rtcac_timebase.tick(3);
    irqchk();
    u_rtcac_timebase.tick(1);
    stat = 1;
    irqchk();
    wrm(16'hF914, 32'h3);
    wrm(16'hF914, 32'h0, 4'($urandom()) & 4'hE);
    irqchk();
    wrm(16'hF918, 32'h0);
    irqchk();
    wrm(16'hF918, 32'h3);
    irqchk();
    wrm(16'hF914, 32'h2);
    irqchk();
    rdchk(16'hF914);
    wrm(16'hF910, 32'hC8);
    wrm(16'hF910, 32'hC0);
    u_rtcac_timebase.tick(11);
    stat = 1;
    irqchk();
    rdchk(16'hF914);
    $display("test alarm done");
    wrm(16'hF910, 32'hC8);
    wrm(16'hF910, 32'h43);
    n = 0;
    while (irq !== 1'b1 && n < 600) begin
      @(negedge clk);
      n++;
    end
    check({31'h0, n inside {[254:264]}}, 32'h1);
    wrm(16'hF910, 32'hC8);
    stat = 2;
    irqchk();
    wrm(16'hF914, 32'h1);
    rdchk(16'hF914);
    $display("test rollover done");
    conclude();
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    conclude();
  end
endmodule // testbench
